// ===== inclination_teach_filter_status_bench.sv
// self-checking bench for teach timing, zero reference, filter choice and indicator
`timescale 1ns/1ps
module inclination_teach_filter_status_bench;
	localparam int TC = 4;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic teach_pin = 1'b0, tool_zero_set = 1'b0, tool_zero_factory = 1'b0;
	logic angle_valid = 1'b1, filter_crit = 1'b0, clr_max = 1'b0;
	logic [15:0] angle_a = 16'h0400, angle_b = 16'hFC00, filter_alpha = 16'h0400;
	logic [15:0] nv_zero_a = 16'h0123, nv_zero_b = 16'h0456;
	logic [1:0] det_open = 2'h0, det_short = 2'h0, det_miswire = 2'h0;
	logic out_valid, zero_store, led_green, led_red;
	logic [15:0] out_a, out_b, zero_a, zero_b, seen_a, seen_b, max_a;
	int num_errors = 0;
	int checked = 0;
	int stores = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// short tick so one second is 4000 clocks
	itfs_teach_filter #(.TICK_CYCLES(TC)) itfs_teach_filter_inst (.clk(clk), .rst_b(rst_b),
		.teach_pin(teach_pin), .tool_zero_set(tool_zero_set), .tool_zero_factory(tool_zero_factory),
		.angle_valid(angle_valid), .angle_a(angle_a), .angle_b(angle_b), .filter_crit(filter_crit),
		.filter_alpha(filter_alpha), .nv_zero_a(nv_zero_a), .nv_zero_b(nv_zero_b), .det_open(det_open),
		.det_short(det_short), .det_miswire(det_miswire), .out_valid(out_valid), .out_a(out_a),
		.out_b(out_b), .zero_a(zero_a), .zero_b(zero_b), .zero_store(zero_store),
		.led_green(led_green), .led_red(led_red));

	itfs_ctrl_model itfs_ctrl_model_inst (.clk(clk), .rst_b(rst_b), .clr_max(clr_max),
		.out_valid(out_valid), .out_a(out_a), .out_b(out_b), .seen_a(seen_a), .seen_b(seen_b),
		.max_a(max_a));

	// count every store request the block raises
	always @(posedge clk) begin
		if (zero_store === 1'b1) stores++;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// sample just after the edge so the edge's updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wait_store(output int n);
		n = 0;
		while (zero_store !== 1'b1 && n < 20000) begin
			cyc(1);
			n++;
		end
	endtask : wait_store

	// bounded so a stuck dark indicator cannot hang the run
	task automatic dark_len(output int n);
		n = 0;
		while (led_green === 1'b0 && led_red === 1'b0 && n < 20000) begin
			cyc(1);
			n++;
		end
	endtask : dark_len

	task automatic t_short();
		@(posedge clk);
		teach_pin <= 1'b1;
		cyc(500 * TC);
		@(posedge clk);
		teach_pin <= 1'b0;
		cyc(20);
		check(16'(stores), 16'h0000);
		check(zero_a, 16'h0123);
		check(led_green, 16'h0001);
	endtask : t_short

	task automatic t_teach(input bit factory);
		int n, d, base, ack;
		@(posedge clk);
		teach_pin <= 1'b1;
		wait_store(n);
		check(16'(n >= 999 * TC && n <= 1000 * TC + 2 * TC + 4), 16'h0001);
		cyc(12); // let the new zero reach the outputs
		check(seen_a, 16'h0000);
		check(seen_b, 16'h0000);
		base = 13;
		if (factory) begin
			wait_store(n);
			check(16'(n + 12 >= 3000 * TC - TC && n + 12 <= 3000 * TC + 2 * TC), 16'h0001);
			check(zero_a, 16'h0000);
			base = 1;
		end
		@(posedge clk);
		teach_pin <= 1'b0;
		dark_len(d);
		ack = factory ? 3000 : 1000;
		check(16'(base + d >= ack * TC - TC && base + d <= ack * TC + 2 * TC), 16'h0001);
		check(led_green, 16'h0001);
	endtask : t_teach

	task automatic t_tool();
		int d;
		@(posedge clk);
		tool_zero_factory <= 1'b1;
		@(posedge clk);
		tool_zero_factory <= 1'b0;
		#1;
		check(zero_store, 16'h0001);
		check(zero_b, 16'h0000);
		@(posedge clk);
		tool_zero_set <= 1'b1;
		@(posedge clk);
		tool_zero_set <= 1'b0;
		#1;
		check(zero_store, 16'h0001);
		cyc(12);
		check(seen_a, 16'h0000);
		// a new event reloads the shorter acknowledgement; twelve dark cycles already passed above
		dark_len(d);
		check(16'(d + 12 >= 1000 * TC - 2 * TC && d + 12 <= 1000 * TC + TC), 16'h0001);
	endtask : t_tool

	// step the angle under the critically damped filter and watch the peak
	task automatic t_crit();
		@(posedge clk);
		filter_crit <= 1'b1;
		clr_max <= 1'b1;
		@(posedge clk);
		clr_max <= 1'b0;
		angle_a <= 16'h1000;
		cyc(3000);
		check(16'($signed(max_a) <= $signed(16'h0C00)), 16'h0001);
		check(16'($signed(seen_a) > $signed(16'h0800)), 16'h0001);
	endtask : t_crit

	// open on either output, short and miswire on the second output only; short is harmless on the current variant
	task automatic t_fault();
		logic [6:0] tbl [4] = '{7'h21, 7'h10, 7'h05, 7'h41};
		foreach (tbl[i]) begin
			@(posedge clk);
			{det_open, det_short, det_miswire} <= tbl[i][6:1];
			cyc(6);
			check(led_red, 16'(tbl[i][0]));
			check(led_green, 16'(!tbl[i][0]));
		end
		@(posedge clk);
		{det_open, det_short, det_miswire} <= 6'h00;
	endtask : t_fault

	// main sequence
	initial begin
		cyc(11);
		check({14'h0000, led_green, led_red}, 16'h0000);
		@(posedge clk);
		rst_b <= 1'b1;
		cyc(1);
		check(zero_a, 16'h0123);
		check(zero_b, 16'h0456);
		cyc(6);
		check(led_green, 16'h0001);
		t_short();
		t_teach(1'b0);
		t_teach(1'b1);
		t_tool();
		t_crit();
		t_fault();
		end_sim();
	end

	// watchdog, well beyond the roughly 1.1 ms the tests need, at exactly 80000 clocks
	initial begin
		#2_000_000;
		num_errors++;
		end_sim();
	end
endmodule : inclination_teach_filter_status_bench

// ===== itfs_ctrl_model.sv
// controller model that reads the analog angle outputs of the sensor
`timescale 1ns/1ps
module itfs_ctrl_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr_max,
	input wire logic out_valid,
	input wire logic [15:0] out_a,
	input wire logic [15:0] out_b,
	output logic [15:0] seen_a,
	output logic [15:0] seen_b,
	output logic [15:0] max_a
);
	// take each sample as offered; the linear variant needs no arcsin step
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seen_a <= 16'h0000;
			seen_b <= 16'h0000;
			max_a <= 16'h8000;
		end else if (clr_max) begin
			max_a <= 16'h8000; // most negative, so any sample wins
		end else if (out_valid) begin
			seen_a <= out_a;
			seen_b <= out_b;
			if ($signed(out_a) > $signed(max_a)) begin
				max_a <= out_a;
			end
		end
	end
endmodule : itfs_ctrl_model

// ===== itfs_pkg.sv
// shared constants and types of the inclination teach, filter and status block
package itfs_pkg;
	// device clock and the slow timer tick derived from it
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

	// teach timing in milliseconds: hold times at the teach input, dark acknowledgement times at the indicator
	localparam int TEACH_MS = 1000;
	localparam int RESTORE_MS = 3000;
	localparam int ACK_ZERO_MS = 1000;
	localparam int ACK_FACTORY_MS = 3000;

	// the same times counted in ticks
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] TEACH_TICKS = CNT_W'(TEACH_MS * 1000 / TICK_US);
	localparam logic [CNT_W-1:0] FACTORY_TICKS = CNT_W'((TEACH_MS + RESTORE_MS) * 1000 / TICK_US);
	localparam logic [CNT_W-1:0] ACK_ZERO_TICKS = CNT_W'(ACK_ZERO_MS * 1000 / TICK_US);
	localparam logic [CNT_W-1:0] ACK_FACTORY_TICKS = CNT_W'(ACK_FACTORY_MS * 1000 / TICK_US);

	// angle path
	localparam int DATA_W = 16;
	localparam int COEF_W = 16;
	localparam int SECTIONS = 4;
	localparam logic [DATA_W-1:0] FACTORY_ZERO = 16'h0000;

	// section damping, Q2.14; 2.0 gives a double real pole per section
	localparam logic [COEF_W-1:0] DAMP_CRIT = 16'h8000;
	localparam logic [COEF_W-1:0] DAMP_BUTTER [SECTIONS] = '{16'h7D8B, 16'h6A6D, 16'h471D, 16'h18F9};

	// cutoff coefficient limits: low end and the two upper ends (ratio 25 to 8)
	localparam logic [COEF_W-1:0] ALPHA_MIN = 16'h0010;
	localparam logic [COEF_W-1:0] ALPHA_MAX_BUTTER = 16'h0FA0;
	localparam logic [COEF_W-1:0] ALPHA_MAX_CRIT = 16'h0500;

	// fault detector bit positions within each two-bit group
	localparam int OUT_A = 0;
	localparam int OUT_B = 1;

	typedef enum logic [1:0] {T_IDLE, T_HOLD, T_TAUGHT, T_RESTORED} itfs_teach_e;
endpackage : itfs_pkg

// ===== itfs_svf_stage.sv
// one second-order low-pass section in state-variable form
`timescale 1ns/1ps
module itfs_svf_stage #(
	parameter int DW = 16,
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	input wire logic [DW-1:0] in_data,
	input wire logic [CW-1:0] alpha,
	input wire logic [CW-1:0] damp,
	output logic out_valid,
	output logic [DW-1:0] out_data
);
	localparam int GW = DW;
	// headroom so the band-pass state of the low-damping section cannot wrap
	localparam int HW = 2;
	localparam int SW = DW + GW + HW;

	typedef struct packed {
		logic v;
		logic signed [SW-1:0] lp;
		logic signed [SW-1:0] bp;
	} itfs_svf_s;

	itfs_svf_s st_reg;
	itfs_svf_s st_next;
	logic signed [SW-1:0] x;
	logic signed [SW-1:0] hp;
	logic signed [SW-1:0] bpn;
	logic signed [SW+CW:0] dbp;
	logic signed [SW+CW:0] ahp;
	logic signed [SW+CW:0] abp;

	if (DW < 8 || CW < 8) begin : g_chk
		$error("itfs_svf_stage: widths below 8 bits are not supported");
	end

	// semi-implicit update: new band-pass feeds the low-pass, stable for small alpha
	always_comb begin
		st_next = st_reg;
		st_next.v = in_valid;
		x = SW'(signed'(in_data)) <<< GW;
		dbp = signed'({1'b0, damp}) * st_reg.bp;
		hp = x - st_reg.lp - SW'(dbp >>> (CW - 2));
		ahp = signed'({1'b0, alpha}) * hp;
		bpn = st_reg.bp + SW'(ahp >>> CW);
		abp = signed'({1'b0, alpha}) * bpn;
		if (in_valid) begin
			st_next.bp = bpn;
			st_next.lp = st_reg.lp + SW'(abp >>> CW);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign out_valid = st_reg.v;
	assign out_data = st_reg.lp[GW+DW-1:GW];
endmodule : itfs_svf_stage

// ===== itfs_teach_filter.sv
// teach timing, zero reference, angle filter and status indicator of the sensor
//
// Contract
// RULE_01: teach input held high one second before a zero teach is acted on.
// RULE_02: valid teach stores present angle as zero so both outputs read zero.
// RULE_03: zero stored is acknowledged by a dark indicator for one second.
// RULE_04: three seconds more of holding restores the factory zero.
// RULE_05: factory restore is acknowledged by a dark indicator for three seconds.
// RULE_06: zero setting accepted from programming tool or teach input.
// RULE_07: angle passes an eighth-order configurable low-pass filter down to 0.1 Hz.
// RULE_08: two filter characteristics, exactly one applied at a time.
// RULE_09: Butterworth cutoff configurable from 0.1 Hz to 25 Hz.
// RULE_10: critically damped cutoff 0.1 Hz to 8 Hz, steps give no overshoot.
// RULE_11: indicator dark only without supply or during a teach acknowledgement.
// RULE_12: indicator green in normal operation with no output fault.
// RULE_13: current variant shows red on open or miswired output.
// RULE_14: voltage variant shows red on shorted or miswired output.
// RULE_15: sine variant drives output as sine of angle, not linearised.
// RULE_16: controller recovers angle by arcsin of normalised output times sine of full scale.
// RULE_17: teach released before one second changes nothing and gives no acknowledgement.
// RULE_18: zero reference and filter choice survive power cycles until changed.
`timescale 1ns/1ps
module itfs_teach_filter #(
	parameter int TICK_CYCLES = itfs_pkg::TICK_CYCLES,
	parameter bit VOLTAGE_IF = 1'b0,
	parameter bit SINE_OUT = 1'b0,
	parameter logic [15:0] ALPHA_MIN = itfs_pkg::ALPHA_MIN,
	parameter logic [15:0] ALPHA_MAX_BUTTER = itfs_pkg::ALPHA_MAX_BUTTER,
	parameter logic [15:0] ALPHA_MAX_CRIT = itfs_pkg::ALPHA_MAX_CRIT
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic teach_pin,
	input wire logic tool_zero_set,
	input wire logic tool_zero_factory,
	input wire logic angle_valid,
	input wire logic [15:0] angle_a,
	input wire logic [15:0] angle_b,
	input wire logic filter_crit,
	input wire logic [15:0] filter_alpha,
	input wire logic [15:0] nv_zero_a,
	input wire logic [15:0] nv_zero_b,
	input wire logic [1:0] det_open,
	input wire logic [1:0] det_short,
	input wire logic [1:0] det_miswire,
	output logic out_valid,
	output logic [15:0] out_a,
	output logic [15:0] out_b,
	output logic [15:0] zero_a,
	output logic [15:0] zero_b,
	output logic zero_store,
	output logic led_green,
	output logic led_red
);
	localparam int DW = itfs_pkg::DATA_W;
	localparam int NS = itfs_pkg::SECTIONS;
	localparam int CNT_W = itfs_pkg::CNT_W;
	localparam int DIV_W = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2 || DW != 16 || itfs_pkg::COEF_W != 16) begin : g_chk
		$error("itfs_teach_filter: tick below 2 cycles or unsupported widths");
	end

	typedef struct packed {
		logic t1;
		logic t2;
		logic [5:0] d1;
		logic [5:0] d2;
		logic [DIV_W-1:0] div;
		logic tick;
		itfs_pkg::itfs_teach_e teach;
		logic [CNT_W-1:0] hold;
		logic [CNT_W-1:0] ack;
		logic loaded;
		logic store;
		logic [DW-1:0] zero_a;
		logic [DW-1:0] zero_b;
		logic ov;
		logic [DW-1:0] oa;
		logic [DW-1:0] ob;
		logic green;
		logic red;
	} itfs_state_s;

	itfs_state_s st_reg;
	itfs_state_s st_next;
	logic [15:0] alpha_eff;
	logic [15:0] alpha_lim;
	logic [DW-1:0] sd [2][NS+1];
	logic sv [2][NS+1];
	logic held;
	logic fault;
	logic teach_set;
	logic factory_set;
	logic [DW-1:0] diff_a;
	logic [DW-1:0] diff_b;

	// 4t(1-|t|) with t = angle over half scale; peak error below six percent
	function automatic logic [DW-1:0] sine_of(input logic [DW-1:0] t);
		logic signed [DW:0] ts;
		logic signed [DW:0] mag;
		logic signed [2*DW+2:0] p;
		logic signed [2*DW+2:0] q;
		logic signed [2*DW+2:0] lim;
		ts = signed'({t[DW-1], t});
		mag = (DW+1)'(1 << (DW - 1)) - (ts < 0 ? -ts : ts);
		p = ts * mag;
		q = p >>> (DW - 3);
		lim = (2*DW+3)'((1 << (DW - 1)) - 1);
		if (q > lim) begin
			q = lim;
		end else if (q < -lim) begin
			q = -lim;
		end
		return q[DW-1:0];
	endfunction : sine_of

	// cutoff clamped to the range of the chosen characteristic
	always_comb begin
		alpha_lim = filter_crit ? ALPHA_MAX_CRIT : ALPHA_MAX_BUTTER; // [RULE_09] [RULE_10]
		if (filter_alpha < ALPHA_MIN) begin
			alpha_eff = ALPHA_MIN; // [RULE_07]
		end else if (filter_alpha > alpha_lim) begin
			alpha_eff = alpha_lim;
		end else begin
			alpha_eff = filter_alpha;
		end
	end

	// four cascaded sections per axis give eighth order
	assign sv[0][0] = angle_valid;
	assign sv[1][0] = angle_valid;
	assign sd[0][0] = angle_a;
	assign sd[1][0] = angle_b;
	for (genvar ax = 0; ax < 2; ax++) begin : g_axis
		for (genvar s = 0; s < NS; s++) begin : g_sec
			itfs_svf_stage #(
				.DW(DW),
				.CW(itfs_pkg::COEF_W)
			) u_sec (
				.clk(clk),
				.rst_b(rst_b),
				.in_valid(sv[ax][s]),
				.in_data(sd[ax][s]),
				.alpha(alpha_eff),
				.damp(filter_crit ? itfs_pkg::DAMP_CRIT : itfs_pkg::DAMP_BUTTER[s]), // [RULE_08] [RULE_10]
				.out_valid(sv[ax][s+1]),
				.out_data(sd[ax][s+1])
			); // [RULE_07]
		end
	end

	assign held = st_reg.t2;
	// the open detector means nothing on a voltage output, the short one nothing on current
	assign fault = VOLTAGE_IF ? |(st_reg.d2[3:2] | st_reg.d2[5:4]) : |(st_reg.d2[1:0] | st_reg.d2[5:4]); // [RULE_13] [RULE_14]
	assign teach_set = (st_reg.teach == itfs_pkg::T_HOLD) && held && st_reg.tick &&
		(st_reg.hold == itfs_pkg::TEACH_TICKS - 1'b1);
	assign factory_set = (st_reg.teach == itfs_pkg::T_TAUGHT) && held && st_reg.tick &&
		(st_reg.hold == itfs_pkg::FACTORY_TICKS - 1'b1);
	assign diff_a = sd[0][NS] - st_reg.zero_a;
	assign diff_b = sd[1][NS] - st_reg.zero_b;

	// next state of synchronisers, timer, teach sequencer, zero and outputs
	always_comb begin
		st_next = st_reg;
		st_next.t1 = teach_pin;
		st_next.t2 = st_reg.t1;
		st_next.d1 = {det_miswire, det_short, det_open};
		st_next.d2 = st_reg.d1;
		st_next.tick = 1'b0;
		if (st_reg.div == DIV_W'(TICK_CYCLES - 1)) begin
			st_next.div = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.div = st_reg.div + 1'b1;
		end
		unique case (st_reg.teach)
			itfs_pkg::T_IDLE: begin
				st_next.hold = '0;
				if (held) begin
					st_next.teach = itfs_pkg::T_HOLD;
				end
			end
			itfs_pkg::T_HOLD, itfs_pkg::T_TAUGHT: begin
				if (!held) begin
					st_next.teach = itfs_pkg::T_IDLE; // [RULE_17]
				end else if (st_reg.tick) begin
					st_next.hold = st_reg.hold + 1'b1; // [RULE_01]
					if (teach_set) begin
						st_next.teach = itfs_pkg::T_TAUGHT;
					end
					if (factory_set) begin
						st_next.teach = itfs_pkg::T_RESTORED; // [RULE_04]
					end
				end
			end
			itfs_pkg::T_RESTORED: begin
				if (!held) begin
					st_next.teach = itfs_pkg::T_IDLE;
				end
			end
		endcase
		// acknowledgement countdown, one step per tick
		if (st_reg.ack != '0 && st_reg.tick) begin
			st_next.ack = st_reg.ack - 1'b1;
		end
		st_next.store = 1'b0;
		if (!st_reg.loaded) begin
			st_next.loaded = 1'b1;
			st_next.zero_a = nv_zero_a; // [RULE_18]
			st_next.zero_b = nv_zero_b;
		end else if (factory_set || tool_zero_factory) begin
			st_next.zero_a = itfs_pkg::FACTORY_ZERO; // [RULE_04] [RULE_06]
			st_next.zero_b = itfs_pkg::FACTORY_ZERO;
			st_next.ack = itfs_pkg::ACK_FACTORY_TICKS; // [RULE_05]
			st_next.store = 1'b1;
		end else if (teach_set || tool_zero_set) begin
			st_next.zero_a = sd[0][NS]; // [RULE_02] [RULE_06]
			st_next.zero_b = sd[1][NS];
			st_next.ack = itfs_pkg::ACK_ZERO_TICKS; // [RULE_03]
			st_next.store = 1'b1; // [RULE_18]
		end
		// referenced outputs, optionally sine shaped
		st_next.ov = sv[0][NS];
		if (sv[0][NS]) begin
			st_next.oa = SINE_OUT ? sine_of(diff_a) : diff_a; // [RULE_15]
			st_next.ob = SINE_OUT ? sine_of(diff_b) : diff_b;
		end
		st_next.green = (st_next.ack == '0) && !fault; // [RULE_11] [RULE_12]
		st_next.red = (st_next.ack == '0) && fault; // [RULE_13] [RULE_14]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign out_valid = st_reg.ov;
	assign out_a = st_reg.oa;
	assign out_b = st_reg.ob;
	assign zero_a = st_reg.zero_a;
	assign zero_b = st_reg.zero_b;
	assign zero_store = st_reg.store;
	assign led_green = st_reg.green;
	assign led_red = st_reg.red;

	// checks on the teach sequence, indicator and cutoff range
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_teach_hold_time: assert property (teach_set |=> st_reg.hold == itfs_pkg::TEACH_TICKS) // [RULE_01]
		else $error("zero teach not at one second of holding");
	a_teach_zero_value: assert property (teach_set && st_reg.loaded && !tool_zero_factory
		|=> zero_a == $past(sd[0][NS]) && zero_b == $past(sd[1][NS]) && zero_store) // [RULE_02]
		else $error("taught zero differs from present angle");
	a_ack_zero_len: assert property (teach_set && st_reg.loaded && !tool_zero_factory
		|=> st_reg.ack == itfs_pkg::ACK_ZERO_TICKS) // [RULE_03]
		else $error("zero acknowledgement length wrong");
	a_factory_hold_time: assert property (factory_set |=> st_reg.hold == itfs_pkg::FACTORY_TICKS
		&& zero_a == itfs_pkg::FACTORY_ZERO) // [RULE_04]
		else $error("factory restore at wrong time or value");
	a_ack_factory_len: assert property (factory_set && st_reg.loaded
		|=> st_reg.ack == itfs_pkg::ACK_FACTORY_TICKS ##1 !led_green && !led_red) // [RULE_05]
		else $error("factory acknowledgement wrong");
	a_led_dark_ack: assert property (st_reg.ack != '0 |-> !led_green && !led_red) // [RULE_11]
		else $error("indicator lit during acknowledgement");
	a_led_green_ok: assert property (st_reg.loaded && st_reg.ack == '0 && !$past(fault) |-> led_green && !led_red) // [RULE_12]
		else $error("indicator not green in normal operation");
	a_led_red_fault: assert property (st_reg.ack == '0 && $past(fault) |-> led_red && !led_green) // [RULE_13] [RULE_14]
		else $error("fault not shown red");
	a_alpha_range: assert property (alpha_eff >= ALPHA_MIN && alpha_eff <= (filter_crit ? ALPHA_MAX_CRIT : ALPHA_MAX_BUTTER)) // [RULE_09]
		else $error("cutoff coefficient out of range");
	a_short_hold_none: assert property (st_reg.teach == itfs_pkg::T_HOLD && !held |=> !zero_store) // [RULE_17]
		else $error("short hold changed the zero");

	c_teach_zero: cover property (teach_set);
	c_teach_factory: cover property (factory_set);
	c_tool_zero: cover property (tool_zero_set && st_reg.loaded);
	c_fault_red: cover property (led_red);
endmodule : itfs_teach_filter
